// >>> core/uart_shadow_defines.vh
`ifndef UART_SHADOW_DEFINES_VH
`define UART_SHADOW_DEFINES_VH

// Base byte address of the sixteen aliased data words
`define SHADOW_BASE 32'h5000_1030
// Byte address of alias ten of the data word
`define SHADOW_TEN 32'h5000_1058
// Size in bytes of the aliased data window
`define SHADOW_SPAN 32'h0000_0040
// Control register byte address
`define CTRL_ADDR 32'h5000_1100
// Line state register byte address
`define LINE_STATE_ADDR 32'h5000_1104

// Control field positions
`define CTRL_FIFO_EN 0
`define CTRL_IR_MODE 1
// Line state field positions
`define LS_RX_READY 0
`define LS_OVERRUN 1
`define LS_TX_EMPTY 5

// Reset values
`define CTRL_RESET 2'h0
`define BYTE_RESET 8'h00
`define WORD_RESET 32'h0000_0000

// FIFO geometry
`define FIFO_DEPTH 5'h10
`define PTR_W 4
`define CNT_W 5
`define PTR_ZERO 4'h0
`define PTR_ONE 4'h1
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01

`endif

// >>> core/uart_shadow_data_port.v
`timescale 1ns/1ps
`include "uart_shadow_defines.vh"

// Summary of operation
// - Sixteen aliased words reach data buffer
// - Read returns serial or infrared received byte
// - No FIFO: new byte overwrites, overrun flagged
// - FIFO mode read pops oldest entry
// - Full receive FIFO drops new byte, overrun
// - Written byte goes to serial or infrared
// - No FIFO: a write clears holding empty
// - No FIFO: extra write replaces pending byte
// - FIFO mode accepts sixteen writes before full
// - Write to full transmit FIFO is dropped
module uart_shadow_data_port
(
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   // Received characters from the serial and infrared framers
   input wire ser_rx_valid_i,
   input wire [7:0] ser_rx_byte_i,
   input wire ir_rx_valid_i,
   input wire [7:0] ir_rx_byte_i,
   // Transmit characters towards the framers
   input wire tx_req_i,
   output reg tx_ser_strobe_o,
   output reg tx_ir_strobe_o,
   output reg [7:0] tx_byte_o
);

   // Address falls inside the aliased data window
   function in_window;
      input [31:0] addr;
      begin
         in_window = (addr >= `SHADOW_BASE) &&
                     (addr < (`SHADOW_BASE + `SHADOW_SPAN)) &&
                     (addr[1:0] == 2'h0);
      end
   endfunction

   // Wrapping pointer advance
   function [`PTR_W-1:0] ptr_next;
      input [`PTR_W-1:0] ptr;
      begin
         ptr_next = ptr + `PTR_ONE;
      end
   endfunction

   // Control bits: FIFO enable and infrared mode
   reg [1:0] ctrl;
   // Sticky receive overrun flag
   reg overrun;
   // Receive holding register for non-FIFO mode
   reg [7:0] rx_hold;
   reg rx_hold_full;
   // Receive FIFO storage and pointers
   reg [7:0] rx_mem [0:15];
   reg [`PTR_W-1:0] rx_rd;
   reg [`PTR_W-1:0] rx_wr;
   reg [`CNT_W-1:0] rx_count;
   // Transmit holding register for non-FIFO mode
   reg [7:0] tx_hold;
   reg tx_hold_full;
   // Transmit FIFO storage and pointers
   reg [7:0] tx_mem [0:15];
   reg [`PTR_W-1:0] tx_rd;
   reg [`PTR_W-1:0] tx_wr;
   reg [`CNT_W-1:0] tx_count;

   // Decoded access and mode terms
   wire fifo_en;
   wire ir_mode;
   wire apb_done;
   wire hit_data;
   wire hit_ctrl;
   wire hit_line;
   wire rd_data_done;
   wire wr_data_done;
   wire wr_ctrl_done;
   wire rd_line_done;
   // Receive path terms
   wire rx_in_valid;
   wire [7:0] rx_in_byte;
   wire rx_ready;
   wire rx_full;
   wire rx_pop;
   wire rx_push;
   wire rx_lost;
   wire [7:0] rx_head;
   // Transmit path terms
   wire tx_empty;
   wire tx_full;
   wire tx_take;
   wire tx_push;
   wire [7:0] tx_head;
   // Next read data and error
   reg [31:0] next_rdata;
   reg next_err;

   assign fifo_en = ctrl[`CTRL_FIFO_EN];
   assign ir_mode = ctrl[`CTRL_IR_MODE];
   // Transfer completes at the edge where pready is seen high
   assign apb_done = psel_i & penable_i & pready_o;
   assign hit_data = in_window(paddr_i);
   assign hit_ctrl = (paddr_i == `CTRL_ADDR);
   assign hit_line = (paddr_i == `LINE_STATE_ADDR);
   assign rd_data_done = apb_done & ~pwrite_i & hit_data;
   assign wr_data_done = apb_done & pwrite_i & hit_data;
   assign wr_ctrl_done = apb_done & pwrite_i & hit_ctrl;
   assign rd_line_done = apb_done & ~pwrite_i & hit_line;

   // Source of received characters follows the mode
   assign rx_in_valid = ir_mode ? ir_rx_valid_i : ser_rx_valid_i;
   assign rx_in_byte = ir_mode ? ir_rx_byte_i : ser_rx_byte_i;
   assign rx_full = (rx_count == `FIFO_DEPTH);
   assign rx_ready = fifo_en ? (rx_count != `CNT_ZERO) : rx_hold_full;
   assign rx_head = fifo_en ? rx_mem[rx_rd] : rx_hold;
   // A data read only consumes a character when one is present
   assign rx_pop = rd_data_done & rx_ready;
   // Full FIFO keeps contents; a same-cycle read frees a slot
   assign rx_push = rx_in_valid & (~rx_full | rx_pop);
   // Arrival onto an unread holding byte or a full FIFO loses a character
   assign rx_lost = rx_in_valid & ~rx_pop &
                    (fifo_en ? rx_full : rx_hold_full);

   assign tx_full = (tx_count == `FIFO_DEPTH);
   assign tx_empty = fifo_en ? (tx_count == `CNT_ZERO) : ~tx_hold_full;
   assign tx_head = fifo_en ? tx_mem[tx_rd] : tx_hold;
   // Framer takes a character only when one is pending
   assign tx_take = tx_req_i & ~tx_empty;
   // Writes to a full FIFO are dropped unless a slot frees now
   assign tx_push = wr_data_done & (~tx_full | tx_take);

   // Read data mux and unmapped address error
   always @*
   begin
      next_rdata = `WORD_RESET;
      next_err = 1'b0;
      if (hit_data)
      begin
         // Low byte carries the character, upper bits read zero
         next_rdata[7:0] = rx_head;
      end
      else if (hit_ctrl)
      begin
         next_rdata[1:0] = ctrl;
      end
      else if (hit_line)
      begin
         // Ready, overrun and holding-empty state
         next_rdata[`LS_RX_READY] = rx_ready;
         next_rdata[`LS_OVERRUN] = overrun;
         next_rdata[`LS_TX_EMPTY] = tx_empty;
      end
      else
      begin
         // Unmapped address answers with an error
         next_err = 1'b1;
      end
   end

   // APB answer: one wait cycle, then pready with data
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         pready_o <= 1'b0;
         prdata_o <= `WORD_RESET;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o <= psel_i & penable_i & ~pready_o;
         if (psel_i & penable_i & ~pready_o)
         begin
            // Data sampled before the pop so it stays stable
            prdata_o <= pwrite_i ? `WORD_RESET : next_rdata;
            pslverr_o <= next_err;
         end
         else
         begin
            prdata_o <= `WORD_RESET;
            pslverr_o <= 1'b0;
         end
      end
   end

   // Control register and sticky overrun flag
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ctrl <= `CTRL_RESET;
         overrun <= 1'b0;
      end
      else
      begin
         if (wr_ctrl_done)
         begin
            ctrl <= pwdata_i[1:0];
         end
         // A new loss wins over the clear-on-read
         if (rx_lost)
         begin
            overrun <= 1'b1;
         end
         else if (rd_line_done)
         begin
            overrun <= 1'b0;
         end
      end
   end

   // Receive holding register and FIFO
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rx_hold <= `BYTE_RESET;
         rx_hold_full <= 1'b0;
         rx_rd <= `PTR_ZERO;
         rx_wr <= `PTR_ZERO;
         rx_count <= `CNT_ZERO;
      end
      else if (wr_ctrl_done)
      begin
         // Mode change flushes both receive stores
         rx_hold_full <= 1'b0;
         rx_rd <= `PTR_ZERO;
         rx_wr <= `PTR_ZERO;
         rx_count <= `CNT_ZERO;
      end
      else if (fifo_en)
      begin
         if (rx_push)
         begin
            rx_mem[rx_wr] <= rx_in_byte;
            rx_wr <= ptr_next(rx_wr);
         end
         if (rx_pop)
         begin
            rx_rd <= ptr_next(rx_rd);
         end
         if (rx_push & ~rx_pop)
         begin
            rx_count <= rx_count + `CNT_ONE;
         end
         else if (rx_pop & ~rx_push)
         begin
            rx_count <= rx_count - `CNT_ONE;
         end
      end
      else
      begin
         if (rx_in_valid)
         begin
            // Newest character always replaces the old one
            rx_hold <= rx_in_byte;
            rx_hold_full <= 1'b1;
         end
         else if (rx_pop)
         begin
            rx_hold_full <= 1'b0;
         end
      end
   end

   // Transmit holding register and FIFO
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         tx_hold <= `BYTE_RESET;
         tx_hold_full <= 1'b0;
         tx_rd <= `PTR_ZERO;
         tx_wr <= `PTR_ZERO;
         tx_count <= `CNT_ZERO;
      end
      else if (wr_ctrl_done)
      begin
         // Mode change flushes both transmit stores
         tx_hold_full <= 1'b0;
         tx_rd <= `PTR_ZERO;
         tx_wr <= `PTR_ZERO;
         tx_count <= `CNT_ZERO;
      end
      else if (fifo_en)
      begin
         if (tx_push)
         begin
            tx_mem[tx_wr] <= pwdata_i[7:0];
            tx_wr <= ptr_next(tx_wr);
         end
         if (tx_take)
         begin
            tx_rd <= ptr_next(tx_rd);
         end
         if (tx_push & ~tx_take)
         begin
            tx_count <= tx_count + `CNT_ONE;
         end
         else if (tx_take & ~tx_push)
         begin
            tx_count <= tx_count - `CNT_ONE;
         end
      end
      else
      begin
         if (wr_data_done)
         begin
            // Write clears holding-empty; a repeat replaces data
            tx_hold <= pwdata_i[7:0];
            tx_hold_full <= 1'b1;
         end
         else if (tx_take)
         begin
            tx_hold_full <= 1'b0;
         end
      end
   end

   // Hand the taken character to the framer of the active mode
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         tx_ser_strobe_o <= 1'b0;
         tx_ir_strobe_o <= 1'b0;
         tx_byte_o <= `BYTE_RESET;
      end
      else
      begin
         tx_ser_strobe_o <= tx_take & ~ir_mode;
         tx_ir_strobe_o <= tx_take & ir_mode;
         if (tx_take)
         begin
            tx_byte_o <= tx_head;
         end
      end
   end

endmodule // uart_shadow_data_port

// >>> dv/uart_shadow_sva.sv
`timescale 1ns/1ps
`include "uart_shadow_defines.vh"
// Watches bus answers and transmit handoff at the port pins
module uart_shadow_sva
(
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Bus side
   input wire psel_i,
   input wire penable_i,
   input wire [31:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   // Framer side
   input wire tx_req_i,
   input wire tx_ser_strobe_o,
   input wire tx_ir_strobe_o,
   input wire [7:0] tx_byte_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Setup cycle of a transfer
   sequence setup_s;
      psel_i && !penable_i;
   endsequence
   // First access cycle, still waiting
   sequence wait_s;
      psel_i && penable_i && !pready_o;
   endsequence
   // Any strobe towards a framer
   wire strobe = tx_ser_strobe_o || tx_ir_strobe_o;
   answer_timing_a: assert property (setup_s ##1 wait_s |=> pready_o)
      else $error("bus answer not after one wait state");
   ready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready held beyond one cycle");
   error_qual_a: assert property (pslverr_o |-> pready_o)
      else $error("error flag without ready");
   data_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data not zero while idle");
   alias_mapped_a: assert property (
      pready_o && paddr_i == `SHADOW_TEN |-> !pslverr_o)
      else $error("alias ten refused");
   strobe_cause_a: assert property (strobe |-> $past(tx_req_i))
      else $error("strobe without framer request");
   one_lane_a: assert property (!(tx_ser_strobe_o && tx_ir_strobe_o))
      else $error("both lanes strobed");
   byte_hold_a: assert property (!strobe |-> $stable(tx_byte_o))
      else $error("transmit byte moved without strobe");
endmodule // uart_shadow_sva

bind uart_shadow_data_port uart_shadow_sva u_sva (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_req_i(tx_req_i),
   .tx_ser_strobe_o(tx_ser_strobe_o), .tx_ir_strobe_o(tx_ir_strobe_o),
   .tx_byte_o(tx_byte_o));

// >>> dv/framer_model.sv
`timescale 1ns/1ps
// Stand-in for the serial and infrared framers
module framer_model
(
   // Clock and bench control
   input wire clk_i,
   input wire take_i,
   // Characters handed out by the port
   input wire ser_strobe_i,
   input wire ir_strobe_i,
   input wire [7:0] byte_i,
   // Request and received characters towards the port
   output reg tx_req_o = 1'b0,
   output reg ser_valid_o = 1'b0,
   output reg ir_valid_o = 1'b0,
   output reg [7:0] ser_byte_o = 8'h00,
   output reg [7:0] ir_byte_o = 8'h00
);
   // Taken characters, lane flag above the byte
   logic [8:0] got[$];
   // Requests only while the bench allows; logs every handoff
   always @(posedge clk_i)
   begin
      tx_req_o <= take_i;
      if (ser_strobe_i || ir_strobe_i)
         got.push_back({ir_strobe_i, byte_i});
   end
   // One-cycle character pulse; byte lines scrambled afterwards
   task send(input ir, input [7:0] b);
      @(posedge clk_i);
      ser_valid_o <= !ir;
      ir_valid_o <= ir;
      ser_byte_o <= b;
      ir_byte_o <= b;
      @(posedge clk_i);
      ser_valid_o <= 1'b0;
      ir_valid_o <= 1'b0;
      ser_byte_o <= ~b;
      ir_byte_o <= ~b;
   endtask
endmodule // framer_model

// >>> dv/test_uart_shadow_data_port.sv
`timescale 1ns/1ps
`include "uart_shadow_defines.vh"
module test_uart_shadow_data_port;
   // Expected line state bits and addresses
   localparam [31:0] EMP = 1 << `LS_TX_EMPTY;
   localparam [31:0] RDY = 1 << `LS_RX_READY;
   localparam [31:0] OVR = 1 << `LS_OVERRUN;
   localparam [31:0] LS = `LINE_STATE_ADDR;
   localparam [31:0] BASE = `SHADOW_BASE;
   // Design pins
   reg clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
   reg pwrite_i = 1'b0, take = 1'b0, err;
   reg [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, r;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, tx_req_i, tx_ser_strobe_o, tx_ir_strobe_o;
   wire ser_rx_valid_i, ir_rx_valid_i;
   wire [7:0] ser_rx_byte_i, ir_rx_byte_i, tx_byte_o;
   integer errors = 0, total_checks = 0, k;
   uart_shadow_data_port DUT (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .ser_rx_valid_i(ser_rx_valid_i),
      .ser_rx_byte_i(ser_rx_byte_i), .ir_rx_valid_i(ir_rx_valid_i),
      .ir_rx_byte_i(ir_rx_byte_i), .tx_req_i(tx_req_i),
      .tx_ser_strobe_o(tx_ser_strobe_o), .tx_ir_strobe_o(tx_ir_strobe_o),
      .tx_byte_o(tx_byte_o));
   framer_model fm (.clk_i(clk_i), .take_i(take),
      .ser_strobe_i(tx_ser_strobe_o), .ir_strobe_i(tx_ir_strobe_o),
      .byte_i(tx_byte_o), .tx_req_o(tx_req_i),
      .ser_valid_o(ser_rx_valid_i), .ir_valid_o(ir_rx_valid_i),
      .ser_byte_o(ser_rx_byte_i), .ir_byte_o(ir_rx_byte_i));
   always #4 clk_i = ~clk_i;
   // Compare and count
   task chk(input [31:0] g, input [31:0] x);
      total_checks++;
      if (g !== x)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // One bus transfer; answer taken at the ready edge
   task xfer(input w, input [31:0] a, input [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      // Values read here are those sampled at this edge
      while (pready_o !== 1'b1)
         @(posedge clk_i);
      r = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      // Idle cycle keeps the next setup off this edge
      @(posedge clk_i);
   endtask
   task rd(input [31:0] a, input [31:0] x);
      xfer(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   task wr(input [31:0] a, input [31:0] d);
      xfer(1'b1, a, d);
   endtask
   // Wait for n logged characters; the watchdog ends a hang
   task wait_tx(input integer n);
      while (fm.got.size() < n)
         @(posedge clk_i);
   endtask
   task test_done;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Cuts a hang short
   initial
   begin
      repeat (20000) @(posedge clk_i);
      errors++;
      test_done;
   end
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      rd(LS, EMP);
      rd(32'h5000_1200, 32'h0);
      chk(err, 1'b1);
      $display("test reset done");
      // Holding register overwrite with FIFOs off
      wr(`SHADOW_TEN, 8'h31);
      rd(LS, 32'h0);
      wr(BASE, 8'h32);
      take <= 1'b1;
      wait_tx(1);
      chk(fm.got.pop_front(), 9'h032);
      rd(LS, EMP);
      // Receive overrun with FIFOs off
      fm.send(1'b0, 8'hA1);
      fm.send(1'b0, 8'hB2);
      rd(LS, EMP | RDY | OVR);
      rd(BASE + 32'h3C, 8'hB2);
      rd(LS, EMP);
      $display("test no fifo done");
      // Receive FIFO: fill past full, drain over all aliases
      wr(`CTRL_ADDR, 32'h1);
      for (k = 0; k < 17; k++)
         fm.send(1'b0, k[7:0]);
      rd(LS, EMP | RDY | OVR);
      for (k = 0; k < 16; k++)
         rd(BASE + 4 * k, k);
      rd(LS, EMP);
      // Transmit FIFO: one write too many while framer stalls
      take <= 1'b0;
      for (k = 0; k < 17; k++)
         wr(BASE + 4 * (k % 16), 8'h40 + k);
      rd(LS, 32'h0);
      take <= 1'b1;
      wait_tx(16);
      // Leave room for a wrongly kept seventeenth character
      repeat (4) @(posedge clk_i);
      chk(fm.got.size(), 16);
      for (k = 0; k < 16; k++)
         chk(fm.got.pop_front(), 8'h40 + k);
      $display("test fifo done");
      // Infrared lanes
      wr(`CTRL_ADDR, 32'h3);
      fm.send(1'b0, 8'h11);
      fm.send(1'b1, 8'h5A);
      rd(`SHADOW_TEN, 8'h5A);
      wr(`SHADOW_TEN, 8'hA5);
      wait_tx(1);
      chk(fm.got.pop_front(), 9'h1A5);
      $display("test infrared done");
      test_done;
   end
endmodule // test_uart_shadow_data_port
